// File: core/rrc_regs.vh
// Register offsets, field layouts and timing counts of the reload timers
`ifndef RRC_REGS_VH
`define RRC_REGS_VH
`define RRC_ADDR_W 32
`define RRC_LONG_RELOAD_LOW 32'h0F000118
`define RRC_LONG_RELOAD_HIGH 32'h0F00011A
`define RRC_LONG_COUNT_LOW 32'h0F00011C
`define RRC_LONG_COUNT_HIGH 32'h0F00011E
`define RRC_CYCLE_RELOAD_LOW 32'h0F000120
`define RRC_CYCLE_RELOAD_HIGH 32'h0F000122
`define RRC_IRQ_FLAGS 32'h0F00013E
`define RRC_LONG_W 24
`define RRC_CYCLE_W 25
`define RRC_LONG_HIGH_W 8
`define RRC_CYCLE_HIGH_W 9
`define RRC_LONG_IRQ_BIT 2
`define RRC_CYCLE_IRQ_BIT 3
`define RRC_CLK_HZ 25000000
`define RRC_LF_HZ 32768
`define RRC_REWRITE_WAIT_US 100
`define RRC_LF_DIV (`RRC_CLK_HZ / `RRC_LF_HZ)
`define RRC_RELOAD_RESET 16'h0000
`endif

// File: core/rrc_lf_tick.v
// Divider making the one-cycle 32.768 kHz tick enable
`timescale 1ns/1ps
`include "rrc_regs.vh"
module rrc_lf_tick
(
  input wire clock,
  input wire rst,
  output reg tick
);
  localparam integer DIV_LAST_INT = `RRC_LF_DIV - 1;
  localparam [9:0] DIV_LAST = DIV_LAST_INT[9:0];
  reg [9:0] div_cnt;

  // Integer divide; the rate error of about 0.12 percent is accepted
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_cnt <= 10'h000;
      tick <= 1'b0;
    end
    else if (div_cnt == DIV_LAST)
    begin
      div_cnt <= 10'h000;
      tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 10'h001;
      tick <= 1'b0;
    end
  end
endmodule

// File: core/rrc_reload_counter.v
// Reload down-counter: counts on enable, pulses and reloads at one
`timescale 1ns/1ps
module rrc_reload_counter
#(
  parameter W = 24
)
(
  input wire clock,
  input wire rst,
  input wire step,
  input wire load,
  input wire [W-1:0] start_value,
  output reg [W-1:0] count,
  output reg hit
);
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= {W{1'b0}};
      hit <= 1'b0;
    end
    else
    begin
      hit <= 1'b0;
      if (load)
        count <= start_value;
      else if (step && start_value != {W{1'b0}})
      begin
        if (count == {{(W-1){1'b0}}, 1'b1} || count == {W{1'b0}})
        begin
          count <= start_value;
          hit <= (count != {W{1'b0}});
        end
        else
          count <= count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: core/rrc_timers.v
// Top: long-period and cycle reload timers with register port
//
// Functional notes
// (R1) Long reload is 24 bits, split low/high
// (R2) Long timer counts from written reload
// (R3) Long reload applies after both halves written
// (R4) Software waits 100 us between reload rewrites
// (R5) All-zero long reload stops the timer
// (R6) Software avoids long reloads one to four
// (R7) Long counter steps per 32.768 kHz period
// (R8) At one: raise request, reload, continue
// (R9) Software reads count twice to confirm
// (R10) Live long count readable in two registers
// (R11) Long reload cleared only by RTC reset
// (R12) Reserved high bits read zero
// (R13) Cycle reload is 25 bits, split low/high
// (R14) Cycle counter counts from written reload
// (R15) Cycle reload applies after both halves
// (R16) All-zero cycle reload stops the counter
// (R17) Cycle counter steps on source clock, reloads
// (R18) Long request sets flag bit 2, write-one clears
// (R19) Cycle request sets flag bit 3, write-one clears
// (R20) Cycle reload cleared by every reset
`timescale 1ns/1ps
`include "rrc_regs.vh"
module rrc_timers
(
  input wire clock,
  input wire rst,
  input wire rtc_domain_reset,
  input wire counter_source_clock,
  input wire [31:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  output wire long_timer_irq_flag,
  output wire cycle_counter_irq_flag
);
  reg [15:0] long_timer_reload_low;
  reg [7:0] long_timer_reload_high;
  reg [15:0] cycle_counter_reload_low;
  reg [8:0] cycle_counter_reload_high;
  reg long_low_seen;
  reg long_high_seen;
  reg cyc_low_seen;
  reg cyc_high_seen;
  reg [23:0] long_start;
  reg [24:0] cyc_start;
  reg long_load;
  reg cyc_load;
  reg [3:2] irq_flags;
  reg src_q1;
  reg src_q2;
  reg src_q3;
  reg [15:0] next_rdata;
  wire lf_tick;
  wire [23:0] long_timer_count_field;
  wire long_hit;
  wire cyc_hit;
  wire src_rise;
  wire any_rst;

  function hit_addr;
    input [31:0] a;
    input [31:0] target;
    begin
      hit_addr = (a == target);
    end
  endfunction

  assign any_rst = rst | rtc_domain_reset;

  // Long reload holds across ordinary resets
  always @(posedge clock or posedge rtc_domain_reset)
  begin
    if (rtc_domain_reset)
    begin
      long_timer_reload_low <= `RRC_RELOAD_RESET; // R11
      long_timer_reload_high <= 8'h00;
    end
    else if (wr)
    begin
      if (hit_addr(addr, `RRC_LONG_RELOAD_LOW))
        long_timer_reload_low <= wdata; // R1
      if (hit_addr(addr, `RRC_LONG_RELOAD_HIGH))
        long_timer_reload_high <= wdata[7:0]; // R1 R12
    end
  end

  always @(posedge clock or posedge any_rst)
  begin
    if (any_rst)
    begin
      cycle_counter_reload_low <= `RRC_RELOAD_RESET; // R20
      cycle_counter_reload_high <= 9'h000;
    end
    else if (wr)
    begin
      if (hit_addr(addr, `RRC_CYCLE_RELOAD_LOW))
        cycle_counter_reload_low <= wdata; // R13
      if (hit_addr(addr, `RRC_CYCLE_RELOAD_HIGH))
        cycle_counter_reload_high <= wdata[8:0]; // R13 R12
    end
  end

  // Pairing of halves and commit of the start value
  always @(posedge clock or posedge any_rst)
  begin
    if (any_rst)
    begin
      long_low_seen <= 1'b0;
      long_high_seen <= 1'b0;
      cyc_low_seen <= 1'b0;
      cyc_high_seen <= 1'b0;
      long_load <= 1'b0;
      cyc_load <= 1'b0;
    end
    else
    begin
      long_load <= 1'b0;
      cyc_load <= 1'b0;
      // Commit clears first, so a half written in the commit cycle stays pending
      if (long_low_seen && long_high_seen)
      begin
        long_low_seen <= 1'b0; // R3
        long_high_seen <= 1'b0;
        long_load <= 1'b1;
      end
      if (cyc_low_seen && cyc_high_seen)
      begin
        cyc_low_seen <= 1'b0; // R15
        cyc_high_seen <= 1'b0;
        cyc_load <= 1'b1;
      end
      if (wr && hit_addr(addr, `RRC_LONG_RELOAD_LOW))
        long_low_seen <= 1'b1;
      if (wr && hit_addr(addr, `RRC_LONG_RELOAD_HIGH))
        long_high_seen <= 1'b1;
      if (wr && hit_addr(addr, `RRC_CYCLE_RELOAD_LOW))
        cyc_low_seen <= 1'b1;
      if (wr && hit_addr(addr, `RRC_CYCLE_RELOAD_HIGH))
        cyc_high_seen <= 1'b1;
    end
  end

  // The long start value survives ordinary resets so the long timer keeps counting
  always @(posedge clock or posedge rtc_domain_reset)
  begin
    if (rtc_domain_reset)
      long_start <= 24'h000000;
    else if (long_low_seen && long_high_seen)
      long_start <= {long_timer_reload_high, long_timer_reload_low}; // R2
  end

  always @(posedge clock or posedge any_rst)
  begin
    if (any_rst)
      cyc_start <= 25'h0000000;
    else if (cyc_low_seen && cyc_high_seen)
      cyc_start <= {cycle_counter_reload_high, cycle_counter_reload_low}; // R14
  end

  rrc_lf_tick u_lf_tick
  (
    .clock(clock),
    .rst(rtc_domain_reset),
    .tick(lf_tick)
  );

  // Long counter resets only with the RTC domain: it keeps counting
  rrc_reload_counter #(.W(`RRC_LONG_W)) u_long
  (
    .clock(clock),
    .rst(rtc_domain_reset),
    .step(lf_tick), // R7 R8 R5
    .load(long_load),
    .start_value(long_start),
    .count(long_timer_count_field),
    .hit(long_hit)
  );

  // Source clock treated as a sampled input; must run below half the clock
  always @(posedge clock or posedge any_rst)
  begin
    if (any_rst)
    begin
      src_q1 <= 1'b0;
      src_q2 <= 1'b0;
      src_q3 <= 1'b0;
    end
    else
    begin
      src_q1 <= counter_source_clock;
      src_q2 <= src_q1;
      src_q3 <= src_q2;
    end
  end

  assign src_rise = src_q2 & ~src_q3;

  rrc_reload_counter #(.W(`RRC_CYCLE_W)) u_cycle
  (
    .clock(clock),
    .rst(any_rst),
    .step(src_rise), // R17 R16
    .load(cyc_load),
    .start_value(cyc_start),
    .count(),
    .hit(cyc_hit)
  );

  // Set wins over a same-cycle write-one clear
  always @(posedge clock or posedge rtc_domain_reset)
  begin
    if (rtc_domain_reset)
      irq_flags <= 2'b00;
    else
    begin
      if (wr && hit_addr(addr, `RRC_IRQ_FLAGS) && wdata[`RRC_LONG_IRQ_BIT])
        irq_flags[2] <= 1'b0;
      if (wr && hit_addr(addr, `RRC_IRQ_FLAGS) && wdata[`RRC_CYCLE_IRQ_BIT])
        irq_flags[3] <= 1'b0;
      if (long_hit)
        irq_flags[2] <= 1'b1; // R18
      if (cyc_hit)
        irq_flags[3] <= 1'b1; // R19
    end
  end

  assign long_timer_irq_flag = irq_flags[2];
  assign cycle_counter_irq_flag = irq_flags[3];

  always @*
  begin
    next_rdata = 16'h0000;
    case (addr)
      `RRC_LONG_RELOAD_LOW: next_rdata = long_timer_reload_low;
      `RRC_LONG_RELOAD_HIGH: next_rdata = {8'h00, long_timer_reload_high}; // R12
      `RRC_LONG_COUNT_LOW: next_rdata = long_timer_count_field[15:0]; // R10
      `RRC_LONG_COUNT_HIGH: next_rdata = {8'h00, long_timer_count_field[23:16]}; // R10
      `RRC_CYCLE_RELOAD_LOW: next_rdata = cycle_counter_reload_low;
      `RRC_CYCLE_RELOAD_HIGH: next_rdata = {7'h00, cycle_counter_reload_high}; // R12
      `RRC_IRQ_FLAGS: next_rdata = {12'h000, irq_flags, 2'b00};
      default: next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clock or posedge any_rst)
  begin
    if (any_rst)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
  end
endmodule

// File: test/rrc_timers_properties.sv
// Checker of the reload timers' register port and flags
`timescale 1ns/1ps
`include "rrc_regs.vh"
module rrc_timers_props
(
  input wire clock,
  input wire rst,
  input wire rtc_domain_reset,
  input wire counter_source_clock,
  input wire [31:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire long_timer_irq_flag,
  input wire cycle_counter_irq_flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst || rtc_domain_reset);
  sequence rd_at(a);
    rd && addr == a;
  endsequence
  // Write then read of one place, with the bench's one-cycle gap
  sequence wr_rd(a);
    wr && addr == a ##2 rd_at(a);
  endsequence
  lh_resv_a: assert property (rd_at(`RRC_LONG_RELOAD_HIGH) |=> rdata[15:8] == 8'h00)
    else $error("long reload high reserved bits set");
  ch_resv_a: assert property (rd_at(`RRC_CYCLE_RELOAD_HIGH) |=> rdata[15:9] == 7'h00)
    else $error("cycle reload high reserved bits set");
  cnt_resv_a: assert property (rd_at(`RRC_LONG_COUNT_HIGH) |=> rdata[15:8] == 8'h00)
    else $error("long count high reserved bits set");
  ll_back_a: assert property (wr_rd(`RRC_LONG_RELOAD_LOW) |=> rdata == $past(wdata, 3))
    else $error("long reload low readback wrong");
  cl_back_a: assert property (wr_rd(`RRC_CYCLE_RELOAD_LOW) |=> rdata == $past(wdata, 3))
    else $error("cycle reload low readback wrong");
  lf_clear_a: assert property ($fell(long_timer_irq_flag) |->
    $past(wr) && $past(addr) == `RRC_IRQ_FLAGS && $past(wdata[2]))
    else $error("long flag fell without a clear");
  cf_clear_a: assert property ($fell(cycle_counter_irq_flag) |->
    $past(wr) && $past(addr) == `RRC_IRQ_FLAGS && $past(wdata[3]))
    else $error("cycle flag fell without a clear");
  flag_rd_a: assert property (rd_at(`RRC_IRQ_FLAGS) |=> rdata[3:2] ==
    {$past(cycle_counter_irq_flag), $past(long_timer_irq_flag)})
    else $error("flag readback wrong");
endmodule
bind rrc_timers rrc_timers_props rrc_timers_props_inst
(
  .clock(clock),
  .rst(rst),
  .rtc_domain_reset(rtc_domain_reset),
  .counter_source_clock(counter_source_clock),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .long_timer_irq_flag(long_timer_irq_flag),
  .cycle_counter_irq_flag(cycle_counter_irq_flag)
);

// File: test/testbench.sv
// Self-checking bench of the reload timers
`timescale 1ns/1ps
`include "rrc_regs.vh"
module testbench;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg rtc_domain_reset = 1'b1;
  reg counter_source_clock = 1'b0;
  reg [31:0] addr = 32'h00000000;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [15:0] rdata;
  wire long_timer_irq_flag;
  wire cycle_counter_irq_flag;
  integer err_count = 0;
  integer tests_run = 0;
  integer div = 0;
  integer i;
  reg [15:0] v;
  time t0;
  rrc_timers rrc_timers_inst
  (
    .clock(clock),
    .rst(rst),
    .rtc_domain_reset(rtc_domain_reset),
    .counter_source_clock(counter_source_clock),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .long_timer_irq_flag(long_timer_irq_flag),
    .cycle_counter_irq_flag(cycle_counter_irq_flag)
  );
  always #20 clock = ~clock;
  // Ten clocks per source period, well inside the sampler's limit
  always @(posedge clock)
  begin
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4)
      counter_source_clock <= ~counter_source_clock;
  end
  task results;
  begin
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Strobe released for one cycle so calls never collide
  task wr_reg(input [31:0] a, input [15:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  end
  endtask
  task chk(input [31:0] a, input [15:0] exp);
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
    @(posedge clock);
  end
  endtask
  task wait_hi(input s);
  begin
    #1;
    repeat (10000)
      if ((s ? cycle_counter_irq_flag : long_timer_irq_flag) !== 1'b1)
        @(posedge clock) #1;
    cmp({15'h0000, s ? cycle_counter_irq_flag : long_timer_irq_flag}, 16'h0001);
    @(posedge clock);
  end
  endtask
  // Pending commit settles, then the stale flag is cleared: the timed gap is one full period
  task period(input s, input [15:0] exp);
  begin
    repeat (4) @(posedge clock);
    wr_reg(`RRC_IRQ_FLAGS, s ? 16'h0008 : 16'h0004);
    wait_hi(s);
    t0 = $time;
    wr_reg(`RRC_IRQ_FLAGS, s ? 16'h0008 : 16'h0004);
    wait_hi(s);
    cmp(16'(($time - t0) / 40), exp);
  end
  endtask
  task quiet(input s, input integer n);
  begin
    repeat (4) @(posedge clock);
    wr_reg(`RRC_IRQ_FLAGS, 16'h000C);
    repeat (n) @(posedge clock);
    #1;
    cmp({15'h0000, s ? cycle_counter_irq_flag : long_timer_irq_flag}, 16'h0000);
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rtc_domain_reset <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 6; i = i + 1)
      chk(`RRC_LONG_RELOAD_LOW + 2 * i, 16'h0000);
    chk(`RRC_IRQ_FLAGS, 16'h0000);
    chk(32'h0F000130, 16'h0000);
    wr_reg(`RRC_LONG_RELOAD_LOW, 16'hABCD);
    chk(`RRC_LONG_RELOAD_LOW, 16'hABCD);
    wr_reg(`RRC_LONG_RELOAD_HIGH, 16'hFF12);
    chk(`RRC_LONG_RELOAD_HIGH, 16'h0012);
    wr_reg(`RRC_LONG_COUNT_HIGH, 16'h0000);
    chk(`RRC_LONG_COUNT_HIGH, 16'h0012);
    chk(`RRC_LONG_COUNT_HIGH, 16'h0012);
    wr_reg(`RRC_CYCLE_RELOAD_LOW, 16'h1234);
    chk(`RRC_CYCLE_RELOAD_LOW, 16'h1234);
    wr_reg(`RRC_CYCLE_RELOAD_HIGH, 16'hFFFF);
    chk(`RRC_CYCLE_RELOAD_HIGH, 16'h01FF);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(`RRC_LONG_RELOAD_LOW, 16'hABCD);
    chk(`RRC_CYCLE_RELOAD_HIGH, 16'h0000);
    $display("register test done");
    wr_reg(`RRC_CYCLE_RELOAD_LOW, 16'h0003);
    wr_reg(`RRC_CYCLE_RELOAD_HIGH, 16'h0000);
    period(1'b1, 16'h001E);
    wr_reg(`RRC_CYCLE_RELOAD_LOW, 16'h0006);
    period(1'b1, 16'h001E);
    wr_reg(`RRC_CYCLE_RELOAD_HIGH, 16'h0000);
    period(1'b1, 16'h003C);
    wr_reg(`RRC_CYCLE_RELOAD_LOW, 16'h0000);
    wr_reg(`RRC_CYCLE_RELOAD_HIGH, 16'h0000);
    quiet(1'b1, 200);
    $display("cycle counter test done");
    repeat (2500) @(posedge clock);
    wr_reg(`RRC_LONG_RELOAD_LOW, 16'h0005);
    wr_reg(`RRC_LONG_RELOAD_HIGH, 16'h0000);
    period(1'b0, 16'(`RRC_LF_DIV * 5));
    chk(`RRC_LONG_COUNT_HIGH, 16'h0000);
    wr_reg(`RRC_LONG_RELOAD_LOW, 16'h0006);
    period(1'b0, 16'(`RRC_LF_DIV * 5));
    wr_reg(`RRC_LONG_RELOAD_HIGH, 16'h0000);
    period(1'b0, 16'(`RRC_LF_DIV * 6));
    wr_reg(`RRC_LONG_RELOAD_LOW, 16'h0000);
    wr_reg(`RRC_LONG_RELOAD_HIGH, 16'h0000);
    quiet(1'b0, 5000);
    $display("long timer test done");
    results;
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    err_count = err_count + 1;
    results;
  end
endmodule
